/* File: hw/smc_map.svh */
// smc_map.svh: register indices, field positions, reset values and counts
// assumes: included by bare name wherever these macros are used
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH

// register indices, byte address is four times the index
`define SMC_IDX_PSC 32'h0fff_f1fe
`define SMC_IDX_STABILIZATION_TIME_SELECT 32'hffff_f6c0
`define SMC_IDX_POWER_SAVE_MODE_SELECT 32'h0fff_f1f0
`define SMC_IDX_STAT 32'h0fff_f1f1

// power_save_control field positions and reset value
`define SMC_PSC_WDT_MASK 6
`define SMC_PSC_PIN_MASK 5
`define SMC_PSC_INT_MASK 4
`define SMC_PSC_STP 1
`define SMC_PSC_RST 8'h00

// power_save_mode_select and stabilization_time_select
`define SMC_POWER_SAVE_MODE_SELECT_RST 2'h0
`define SMC_STABILIZATION_TIME_SELECT_RST 3'h6
`define SMC_STABILIZATION_TIME_SELECT_BAD 3'h7

// wait lengths: 2^(base+code) main clocks, 12 subclock cycles
`define SMC_WAIT_BASE 10
`define SMC_SUB_WAIT 4'hc

`endif

/* File: hw/smc_pkg.sv */
// smc_pkg.sv: types shared by the standby mode controller
// assumes: smc_map.svh is on the include path
`include "smc_map.svh"

package smc_pkg;

    // controller states
    typedef enum logic [2:0] {
        ST_RUN        = 3'b000,
        ST_HALT       = 3'b001,
        ST_LIGHT_IDLE = 3'b010,
        ST_DEEP_IDLE  = 3'b011,
        ST_STOP       = 3'b100,
        ST_SUB_IDLE   = 3'b101,
        ST_SUB_WAIT   = 3'b110,
        ST_STAB       = 3'b111
    } smc_state_t;

    // release sources seen by the controller
    typedef struct packed {
        logic wdt_nmi;
        logic pin_nmi;
        logic irq;
    } smc_wake_t;

    // mode-select field decode, sub selects the subclock variant
    function automatic smc_state_t smc_decode_mode(input logic [1:0] sel, input logic sub);
        smc_state_t s;
        s = ST_STOP;
        unique case (sel)
            2'b00: s = sub ? ST_SUB_IDLE : ST_LIGHT_IDLE;
            2'b01: s = sub ? ST_SUB_IDLE : ST_STOP;
            2'b10: s = sub ? ST_SUB_IDLE : ST_DEEP_IDLE;
            2'b11: s = ST_STOP;
        endcase
        return s;
    endfunction : smc_decode_mode

endpackage : smc_pkg

/* File: hw/smc_stab_counter.sv */
// smc_stab_counter.sv: oscillation stabilisation / setup wait counter
// assumes: pclk is the main clock; run is high only while it oscillates
`timescale 1ns/1ps
`include "smc_map.svh"

module smc_stab_counter #(
    parameter int BASE = `SMC_WAIT_BASE,
    parameter int CW = 17
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [2:0] code,
    input wire logic run,
    output logic done
);
    // wait length for a code, 2^(BASE+code) cycles
    function automatic logic [CW-1:0] wait_len(input logic [2:0] c);
        logic [CW-1:0] one;
        one = {{(CW-1){1'b0}}, 1'b1};
        return one << (BASE + int'(c));
    endfunction : wait_len

    localparam logic [CW-1:0] RST_LEN = wait_len(`SMC_STABILIZATION_TIME_SELECT_RST);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // load on entry, count down only while the oscillator runs
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = wait_len(code);
        end else if (run && cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // reset loads the post-reset wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= RST_LEN;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == '0) && !load;
endmodule : smc_stab_counter

/* File: hw/smc_sync.sv */
// smc_sync.sv: two-flop synchroniser for asynchronous levels
// assumes: inputs are slow levels, one bit per independent signal
`timescale 1ns/1ps

module smc_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end

    assign q = s2_q;
endmodule : smc_sync

/* File: hw/smc_top.sv */
// smc_top.sv: standby mode controller with an APB register slave
// assumes: pclk is the main clock, interrupt and watchdog inputs are on
// pclk, pin-level and oscillator inputs are asynchronous
//
// Functional notes
// - halt stops only the cpu clock
// - halt instruction enters halt, no register write
// - halt with pending request leaves at once
// - halt released by nmi, interrupt or reset
// - standby bit enters selected software standby mode
// - mode field picks light, stop, deep, stop; sub_clock_mode picks sub except for 11
// - mode field acts only with standby bit
// - control register written only through protected sequence
// - watchdog mask blocks watchdog standby release
// - pin mask blocks pin nmi standby release
// - maskable mask blocks interrupt standby release
// - masks ignored for halt release
// - light idle returns to run at once
// - deep idle waits selected setup time
// - stop halts all but subclock, then waits
// - sub idle release waits twelve subclock cycles
// - wait is 2^(10+code) clocks, 111 prohibited
// - wait code resets to six
// - stop wait counts only once oscillator runs
// - watchdog overflow in wait selects internal oscillator
// - halt release leaves request priority to controller
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "smc_map.svh"

module smc_top import smc_pkg::*; #(
    parameter int WAIT_BASE = `SMC_WAIT_BASE,
    parameter int AW = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic special_seq_ok,
    input wire logic halt_exec,
    input wire logic irq_pending,
    input wire logic watchdog_nonmaskable_request,
    input wire logic nmi_pin,
    input wire logic wdt_overflow,
    input wire logic sub_clock_mode,
    input wire logic subclk_in,
    input wire logic osc_started,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic main_osc_en,
    output logic pll_flash_en,
    output logic cpu_int_osc,
    output logic stab_busy,
    output logic [2:0] standby_state
);
    // index match on the word address bits
    function automatic logic idx_hit(input logic [AW-1:0] a, input logic [31:0] idx);
        return a[AW-1:2] == idx[AW-3:0];
    endfunction : idx_hit

    // asynchronous inputs through two flops
    logic [2:0] sync_out;
    smc_sync #(.W(3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({nmi_pin, osc_started, subclk_in}),
        .q(sync_out)
    );

    logic pin_s;
    logic osc_s;
    logic sub_s;
    assign pin_s = sync_out[2];
    assign osc_s = sync_out[1];
    assign sub_s = sync_out[0];

    smc_wake_t wake;
    assign wake = '{wdt_nmi: watchdog_nonmaskable_request, pin_nmi: pin_s, irq: irq_pending};

    // registers
    logic wdt_mask_q, wdt_mask_d;
    logic pin_mask_q, pin_mask_d;
    logic int_mask_q, int_mask_d;
    logic stp_q, stp_d;
    logic [1:0] psm_q, psm_d;
    logic [2:0] stabilization_time_select_q, stabilization_time_select_d;
    smc_state_t state_q, state_d;
    logic [3:0] sub_cnt_q, sub_cnt_d;
    logic sub_prev_q;
    logic int_osc_q, int_osc_d;
    logic cpu_clk_en_q, periph_clk_en_q, main_osc_en_q, pll_flash_en_q, stab_busy_q;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;

    // bus phases
    logic setup;
    logic access;
    logic hit_psc, hit_stabilization_time_select, hit_power_save_mode_select, hit_stat, hit_any;
    logic wr;
    assign setup = psel && !penable;
    assign access = psel && penable && pready_q;
    assign hit_psc = idx_hit(paddr, `SMC_IDX_PSC);
    assign hit_stabilization_time_select = idx_hit(paddr, `SMC_IDX_STABILIZATION_TIME_SELECT);
    assign hit_power_save_mode_select = idx_hit(paddr, `SMC_IDX_POWER_SAVE_MODE_SELECT);
    assign hit_stat = idx_hit(paddr, `SMC_IDX_STAT);
    assign hit_any = hit_psc || hit_stabilization_time_select || hit_power_save_mode_select || hit_stat;
    assign wr = access && pwrite && hit_any;

    // release terms
    logic halt_wake;
    logic sb_wake;
    logic stab_done;
    logic stab_load;
    logic sub_edge;
    assign halt_wake = wake.wdt_nmi || wake.pin_nmi || wake.irq;
    assign sb_wake = (wake.wdt_nmi && !wdt_mask_q)
        || (wake.pin_nmi && !pin_mask_q)
        || (wake.irq && !int_mask_q);
    assign stab_load = (state_d == ST_STAB) && (state_q != ST_STAB);
    assign sub_edge = sub_s && !sub_prev_q;

    smc_stab_counter #(.BASE(WAIT_BASE), .CW(WAIT_BASE + 7)) u_stab (
        .pclk(pclk),
        .presetn(presetn),
        .load(stab_load),
        .code(stabilization_time_select_q),
        .run(osc_s),
        .done(stab_done)
    );

    // mode sequencer next state
    always_comb begin
        state_d = state_q;
        sub_cnt_d = sub_cnt_q;
        unique case (state_q)
            ST_RUN: begin
                if (halt_exec) begin
                    state_d = ST_HALT;
                end else if (stp_q) begin
                    state_d = smc_decode_mode(psm_q, sub_clock_mode);
                end
            end
            ST_HALT: begin
                // pending requests stay with the interrupt controller
                if (halt_wake) begin
                    state_d = ST_RUN;
                end
            end
            ST_LIGHT_IDLE: begin
                if (sb_wake) begin
                    state_d = ST_RUN;
                end
            end
            ST_DEEP_IDLE: begin
                if (sb_wake) begin
                    state_d = ST_STAB;
                end
            end
            ST_STOP: begin
                if (sb_wake) begin
                    state_d = ST_STAB;
                end
            end
            ST_SUB_IDLE: begin
                sub_cnt_d = 4'h0;
                if (sb_wake) begin
                    state_d = ST_SUB_WAIT;
                end
            end
            ST_SUB_WAIT: begin
                if (sub_cnt_q == `SMC_SUB_WAIT) begin
                    state_d = ST_RUN;
                end else if (sub_edge) begin
                    sub_cnt_d = sub_cnt_q + 4'h1;
                end
            end
            ST_STAB: begin
                if (stab_done) begin
                    state_d = ST_RUN;
                end
            end
        endcase
    end

    // register writes; a write in the release cycle wins over the clear
    always_comb begin
        wdt_mask_d = wdt_mask_q;
        pin_mask_d = pin_mask_q;
        int_mask_d = int_mask_q;
        stp_d = stp_q;
        psm_d = psm_q;
        stabilization_time_select_d = stabilization_time_select_q;
        if (state_q != ST_RUN && state_q != ST_HALT && state_q != state_d) begin
            stp_d = 1'b0;
        end
        if (wr && hit_psc && special_seq_ok) begin
            wdt_mask_d = pwdata[`SMC_PSC_WDT_MASK];
            pin_mask_d = pwdata[`SMC_PSC_PIN_MASK];
            int_mask_d = pwdata[`SMC_PSC_INT_MASK];
            stp_d = pwdata[`SMC_PSC_STP];
        end
        if (wr && hit_power_save_mode_select) begin
            psm_d = pwdata[1:0];
        end
        if (wr && hit_stabilization_time_select && pwdata[2:0] != `SMC_STABILIZATION_TIME_SELECT_BAD) begin
            stabilization_time_select_d = pwdata[2:0];
        end
    end

    // bus answer: pready one cycle after setup, read data latched at setup
    always_comb begin
        pready_d = setup;
        pslverr_d = setup && !hit_any;
        prdata_d = prdata_q;
        if (setup) begin
            prdata_d = 32'h0000_0000;
            if (hit_psc) begin
                prdata_d[`SMC_PSC_WDT_MASK] = wdt_mask_q;
                prdata_d[`SMC_PSC_PIN_MASK] = pin_mask_q;
                prdata_d[`SMC_PSC_INT_MASK] = int_mask_q;
                prdata_d[`SMC_PSC_STP] = stp_q;
            end else if (hit_power_save_mode_select) begin
                prdata_d[1:0] = psm_q;
            end else if (hit_stabilization_time_select) begin
                prdata_d[2:0] = stabilization_time_select_q;
            end else if (hit_stat) begin
                prdata_d[4:0] = {stab_busy_q, int_osc_q, state_q};
            end
        end
    end

    // internal oscillator takeover is sticky until reset
    always_comb begin
        int_osc_d = int_osc_q;
        if (state_q == ST_STAB && wdt_overflow) begin
            int_osc_d = 1'b1;
        end
    end

    // all state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_STAB;
            sub_cnt_q <= 4'h0;
            sub_prev_q <= 1'b0;
            wdt_mask_q <= 1'(`SMC_PSC_RST >> `SMC_PSC_WDT_MASK);
            pin_mask_q <= 1'(`SMC_PSC_RST >> `SMC_PSC_PIN_MASK);
            int_mask_q <= 1'(`SMC_PSC_RST >> `SMC_PSC_INT_MASK);
            stp_q <= 1'(`SMC_PSC_RST >> `SMC_PSC_STP);
            psm_q <= `SMC_POWER_SAVE_MODE_SELECT_RST;
            stabilization_time_select_q <= `SMC_STABILIZATION_TIME_SELECT_RST;
            int_osc_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            cpu_clk_en_q <= 1'b0;
            periph_clk_en_q <= 1'b0;
            main_osc_en_q <= 1'b1;
            pll_flash_en_q <= 1'b1;
            stab_busy_q <= 1'b1;
        end else begin
            state_q <= state_d;
            sub_cnt_q <= sub_cnt_d;
            sub_prev_q <= sub_s;
            wdt_mask_q <= wdt_mask_d;
            pin_mask_q <= pin_mask_d;
            int_mask_q <= int_mask_d;
            stp_q <= stp_d;
            psm_q <= psm_d;
            stabilization_time_select_q <= stabilization_time_select_d;
            int_osc_q <= int_osc_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            // clock gates follow the next state
            cpu_clk_en_q <= state_d == ST_RUN;
            periph_clk_en_q <= state_d inside {ST_RUN, ST_HALT};
            main_osc_en_q <= !(state_d inside {ST_STOP, ST_SUB_IDLE, ST_SUB_WAIT});
            pll_flash_en_q <= state_d inside {ST_RUN, ST_HALT, ST_LIGHT_IDLE, ST_STAB};
            stab_busy_q <= state_d inside {ST_STAB, ST_SUB_WAIT};
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cpu_clk_en = cpu_clk_en_q;
    assign periph_clk_en = periph_clk_en_q;
    assign main_osc_en = main_osc_en_q;
    assign pll_flash_en = pll_flash_en_q;
    assign cpu_int_osc = int_osc_q;
    assign stab_busy = stab_busy_q;
    assign standby_state = state_q;

    // checks on the sequencer
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_halt_clocks: assert property (
        state_q == ST_HALT |-> !cpu_clk_en_q && periph_clk_en_q && main_osc_en_q)
        else $error("halt gates more than the cpu clock");
    a_halt_entry: assert property (
        state_q == ST_RUN && halt_exec |=> state_q == ST_HALT)
        else $error("halt instruction did not enter halt");
    a_halt_pending: assert property (
        state_q == ST_RUN && halt_exec && irq_pending |=> state_q == ST_HALT ##1 state_q == ST_RUN)
        else $error("pending request did not end halt at once");
    a_halt_nomask: assert property (
        state_q == ST_HALT && wake.irq && int_mask_q |=> state_q == ST_RUN && cpu_clk_en_q)
        else $error("mask bit blocked halt release");
    a_stop_decode: assert property (
        state_q == ST_RUN && !halt_exec && stp_q && psm_q == 2'b11 |=> state_q == ST_STOP)
        else $error("mode 11 did not enter stop");
    a_no_stp_run: assert property (
        state_q == ST_RUN && !stp_q && !halt_exec |=> state_q == ST_RUN)
        else $error("left run without standby bit");
    a_plain_store: assert property (
        wr && hit_psc && !special_seq_ok && state_q == ST_RUN |=> $stable(stp_q) && $stable(int_mask_q))
        else $error("plain store changed control register");
    a_wdt_masked: assert property (state_q inside {ST_DEEP_IDLE, ST_STOP} &&
        wake == 3'b100 && wdt_mask_q |=> $stable(state_q))
        else $error("masked watchdog released standby");
    a_pin_masked: assert property (
        state_q == ST_LIGHT_IDLE && wake == 3'b010 && pin_mask_q |=> state_q == ST_LIGHT_IDLE)
        else $error("masked pin released standby");
    a_light_fast: assert property (
        state_q == ST_LIGHT_IDLE && sb_wake |=> state_q == ST_RUN && !stp_q)
        else $error("light idle release not immediate");
    a_deep_wait: assert property (
        state_q == ST_DEEP_IDLE && sb_wake |=> state_q == ST_STAB [*2])
        else $error("deep idle skipped setup wait");
    a_stop_osc: assert property (
        state_q == ST_STOP |-> !main_osc_en_q && !cpu_clk_en_q && !pll_flash_en_q)
        else $error("stop left a clock running");
    a_sub_wait: assert property (
        state_q == ST_SUB_IDLE && sb_wake |=> !cpu_clk_en_q [*3])
        else $error("sub idle release did not wait");
    a_stabilization_time_select_legal: assert property (
        stabilization_time_select_q != `SMC_STABILIZATION_TIME_SELECT_BAD)
        else $error("prohibited wait code stored");
    a_osc_hold: assert property (
        state_q == ST_STAB && !osc_s && !stab_done |=> state_q == ST_STAB)
        else $error("wait ended without oscillator");
    a_int_osc: assert property (
        state_q == ST_STAB && wdt_overflow |=> cpu_int_osc)
        else $error("watchdog overflow did not select internal oscillator");

    c_halt_cycle: cover property (state_q == ST_HALT ##1 state_q == ST_RUN);
    c_stop_release: cover property (state_q == ST_STOP ##1 state_q == ST_STAB);
    c_sub_release: cover property (state_q == ST_SUB_WAIT ##1 state_q == ST_RUN);
    c_deep_release: cover property (state_q == ST_DEEP_IDLE ##1 state_q == ST_STAB);
endmodule : smc_top

/* File: testbench/tb_top.sv */
// tb_top.sv: self-checking bench for the standby mode controller
// assumes: smc_top with an APB slave, pclk at 250 MHz, WAIT_BASE shortened to 1
`timescale 1ns/1ps
`include "smc_map.svh"

module tb_top import smc_pkg::*;;
    localparam int WB = 1;
    localparam logic [11:0] A_PSC = 12'(`SMC_IDX_PSC << 2);
    localparam logic [11:0] A_STABILIZATION_TIME_SELECT = 12'(`SMC_IDX_STABILIZATION_TIME_SELECT << 2);
    localparam logic [11:0] A_POWER_SAVE_MODE_SELECT = 12'(`SMC_IDX_POWER_SAVE_MODE_SELECT << 2);
    localparam logic [11:0] A_STAT = 12'(`SMC_IDX_STAT << 2);
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, seed = 32'h0000_0033;
    logic pready, pslverr, special_seq_ok = 1'b0, halt_exec = 1'b0, irq_pending = 1'b0;
    logic watchdog_nonmaskable_request = 1'b0, nmi_pin = 1'b0, wdt_overflow = 1'b0;
    logic sub_clock_mode = 1'b0, subclk_in = 1'b0, osc_started = 1'b1;
    logic cpu_clk_en, periph_clk_en, main_osc_en, pll_flash_en, cpu_int_osc, stab_busy;
    logic [2:0] standby_state;
    logic [32:0] exp_q[$];
    logic [32:0] mon_e;
    int fails = 0, check_count = 0;

    smc_top #(.WAIT_BASE(WB)) smc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .special_seq_ok(special_seq_ok),
        .halt_exec(halt_exec), .irq_pending(irq_pending),
        .watchdog_nonmaskable_request(watchdog_nonmaskable_request), .nmi_pin(nmi_pin),
        .wdt_overflow(wdt_overflow), .sub_clock_mode(sub_clock_mode), .subclk_in(subclk_in),
        .osc_started(osc_started), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .main_osc_en(main_osc_en), .pll_flash_en(pll_flash_en), .cpu_int_osc(cpu_int_osc),
        .stab_busy(stab_busy), .standby_state(standby_state));

    // clock and run-time guard
    always #2 pclk = ~pclk;
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // one APB transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        if (w) chk(33'(pslverr), 33'h0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic wpsc(input logic [31:0] d, input logic ok);
        @(posedge pclk);
        special_seq_ok <= ok;
        apb(1'b1, A_PSC, d);
        special_seq_ok <= 1'b0;
    endtask : wpsc

    task automatic wait_st(input smc_state_t s, input int lim);
        int n;
        n = 0;
        while (standby_state !== s && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk(33'(standby_state), 33'(s));
    endtask : wait_st

    task automatic set_src(input int s, input logic v);
        case (s)
            0: watchdog_nonmaskable_request <= v;
            1: nmi_pin <= v;
            default: irq_pending <= v;
        endcase
    endtask : set_src

    // read monitor: oldest note against what the slave returns
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            mon_e = exp_q.size() > 0 ? exp_q.pop_front() : 33'h0_dead_beef;
            if (mon_e[32]) chk({pslverr, 32'h0000_0000}, {1'b1, 32'h0000_0000});
            else chk({pslverr, prdata}, mon_e);
        end
    end

    initial begin
        smc_state_t ex[4];
        logic [2:0] code;
        int n, lo, s, m;
        ex = '{ST_LIGHT_IDLE, ST_STOP, ST_DEEP_IDLE, ST_STOP};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        n = 0;
        while (standby_state !== ST_RUN && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk(33'(n >= 128 && n <= 134), 33'h1);
        chk(33'(cpu_clk_en), 33'h1);
        rd(A_PSC, 33'h0);
        rd(A_STABILIZATION_TIME_SELECT, 33'h6);
        rd(A_POWER_SAVE_MODE_SELECT, 33'h0);
        wpsc(32'h0000_0072, 1'b0);
        rd(A_PSC, 33'h0);
        apb(1'b1, A_STABILIZATION_TIME_SELECT, 32'h0000_0003);
        apb(1'b1, A_STABILIZATION_TIME_SELECT, 32'h0000_0007);
        rd(A_STABILIZATION_TIME_SELECT, 33'h3);
        // each mode code, one source allowed and another masked
        for (int i = 0; i < 4; i++) begin
            s = i % 3;
            m = (i + 1) % 3;
            code = 3'(xs() % 7);
            apb(1'b1, A_STABILIZATION_TIME_SELECT, 32'(code));
            apb(1'b1, A_POWER_SAVE_MODE_SELECT, 32'(i)); // mode field before standby bit
            chk(33'(standby_state), 33'(ST_RUN));
            wpsc(32'h0000_0072 & ~(32'h1 << (6 - s)), 1'b1);
            wait_st(ex[i], 8);
            chk(33'(main_osc_en), 33'(ex[i] != ST_STOP));
            if (ex[i] == ST_STOP) osc_started <= 1'b0;
            set_src(m, 1'b1);
            repeat (8) @(posedge pclk);
            chk(33'(standby_state), 33'(ex[i]));
            set_src(m, 1'b0);
            repeat (3) @(posedge pclk);
            set_src(s, 1'b1);
            if (ex[i] == ST_LIGHT_IDLE) begin
                wait_st(ST_RUN, 6);
            end else begin
                wait_st(ST_STAB, 6);
                chk(33'(stab_busy), 33'h1);
                set_src(s, 1'b0);
                // oscillator still off after stop: the wait must not run yet
                if (ex[i] == ST_STOP) begin
                    repeat (10) @(posedge pclk);
                    chk(33'(standby_state), 33'(ST_STAB));
                    wdt_overflow <= 1'b1;
                    @(posedge pclk);
                    wdt_overflow <= 1'b0;
                    osc_started <= 1'b1;
                end
                lo = 2 ** (WB + int'(code));
                n = 0;
                while (standby_state === ST_STAB && n < 600) begin
                    @(posedge pclk);
                    n++;
                end
                chk(33'(n >= lo && n <= lo + 6), 33'h1);
                chk({31'h0, stab_busy, cpu_int_osc}, 33'h1);
            end
            set_src(s, 1'b0);
            osc_started <= 1'b1;
            repeat (3) @(posedge pclk);
            rd(A_PSC, 33'(32'h0000_0070 & ~(32'h1 << (6 - s))));
        end
        // halt with all release masks set
        wpsc(32'h0000_0070, 1'b1);
        @(posedge pclk);
        halt_exec <= 1'b1;
        @(posedge pclk);
        halt_exec <= 1'b0;
        wait_st(ST_HALT, 3);
        chk({30'h0, cpu_clk_en, periph_clk_en, pll_flash_en}, 33'h3);
        irq_pending <= 1'b1;
        wait_st(ST_RUN, 3);
        repeat (5) @(posedge pclk); // idle slots after halt
        halt_exec <= 1'b1;
        @(posedge pclk);
        halt_exec <= 1'b0;
        wait_st(ST_HALT, 3);
        wait_st(ST_RUN, 3);
        irq_pending <= 1'b0;
        // sub idle, released by the pin, then twelve subclock edges
        sub_clock_mode <= 1'b1;
        apb(1'b1, A_POWER_SAVE_MODE_SELECT, 32'h0000_0000);
        wpsc(32'h0000_0052, 1'b1);
        wait_st(ST_SUB_IDLE, 8);
        nmi_pin <= 1'b1;
        wait_st(ST_SUB_WAIT, 6);
        nmi_pin <= 1'b0;
        for (int k = 0; k < 12; k++) begin
            if (k == 11) chk(33'(standby_state), 33'(ST_SUB_WAIT));
            subclk_in <= 1'b1;
            repeat (3) @(posedge pclk);
            subclk_in <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        wait_st(ST_RUN, 8);
        sub_clock_mode <= 1'b0;
        rd(A_STAT, 33'h08);
        rd(12'h004, {1'b1, 32'h0000_0000});
        repeat (4) @(posedge pclk);
        report_and_stop();
    end
endmodule : tb_top
